// ### verilog/pecd_pkg.sv
package pecd_pkg;
  // Register byte offsets.
  localparam logic [11:0] CARD_CLOCK_DIV_OFS = 12'h02C;
  localparam logic [11:0] SERIAL_CLOCK_DIV_A_OFS = 12'h030;
  localparam logic [11:0] SERIAL_CLOCK_DIV_B_OFS = 12'h034;
  localparam logic [11:0] CARD_AND_SERIAL_CLOCK_DIV_OFS = 12'h038;
  localparam logic [11:0] CONVERTER_CLOCK_DIV_OFS = 12'h03C;
  localparam logic [11:0] TIMER_WATCHDOG_CLOCK_SEL_OFS = 12'h040;

  // Reset values.
  localparam logic [31:0] CARD_CLOCK_DIV_RST = 32'h0000_0000;
  localparam logic [31:0] SERIAL_CLOCK_DIV_A_RST = 32'h0000_0000;
  localparam logic [31:0] SERIAL_CLOCK_DIV_B_RST = 32'h0000_0000;
  localparam logic [31:0] CARD_AND_SERIAL_CLOCK_DIV_RST = 32'h0000_0000;
  localparam logic [31:0] CONVERTER_CLOCK_DIV_RST = 32'h0000_0000;
  localparam logic [31:0] TIMER_WATCHDOG_CLOCK_SEL_RST = 32'h0000_0500;

  // Writable bits; reserved bits read as zero.
  localparam logic [31:0] CARD_CLOCK_DIV_MASK = 32'h0000_FF18;
  localparam logic [31:0] SERIAL_CLOCK_DIV_MASK = 32'hF8F8_F8F8;
  localparam logic [31:0] CARD_AND_SERIAL_CLOCK_DIV_MASK = 32'h7F00_F8F8;
  localparam logic [31:0] CONVERTER_CLOCK_DIV_MASK = 32'hFF18_0000;
  localparam logic [31:0] TIMER_WATCHDOG_CLOCK_SEL_MASK = 32'h0FFF_0FFF;

  // Serial port fields: four ports per register (two in the card and serial register), one byte lane each.
  localparam int SERIAL_PER_REG = 4;
  localparam int SERIAL_LANE_W = 8;
  localparam int SERIAL_DIV_LSB = 5;
  localparam int SERIAL_SEL_LSB = 3;
  localparam int SMARTCARD1_DIV_LSB = 28;
  localparam int SMARTCARD0_DIV_LSB = 24;
  localparam int CONVERTER_DIV_LSB = 24;
  localparam int CONVERTER_SEL_LSB = 19;
  localparam int CARD0_DIV_LSB = 8;
  localparam int CARD0_SEL_LSB = 3;

  // Source selection encodings.
  localparam logic [1:0] SEL_MAIN = 2'h0;
  localparam logic [1:0] SEL_LOW_OR_RSVD = 2'h1;
  localparam logic [1:0] SEL_FIRST_PLL = 2'h2;
  localparam logic [1:0] SEL_SECOND_PLL = 2'h3;

  // Source clock indices.
  localparam int NUM_SRC = 5;
  localparam logic [2:0] SRC_TWELVE = 3'h4;

  // Engine clock channel indices.
  localparam int NUM_SERIAL = 10;
  localparam int CH_SMARTCARD0 = 10;
  localparam int CH_SMARTCARD1 = 11;
  localparam int CH_CONVERTER = 12;
  localparam int CH_CARD0 = 13;
  localparam int NUM_CH = 14;
endpackage : pecd_pkg

// ### verilog/pecd_clock_div.sv
`timescale 1ns/10ps
module pecd_clock_div
  import pecd_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic main_crystal_clock,
  input wire logic low_speed_crystal_clock,
  input wire logic first_pll_derived_clock,
  input wire logic second_pll_derived_clock,
  input wire logic twelve_mhz_crystal,
  output logic [NUM_SERIAL-1:0] serial_engine_clock,
  output logic [1:0] smartcard_engine_clock,
  output logic converter_engine_clock,
  output logic card0_engine_clock,
  output logic [31:0] timer_watchdog_clock_sel
);

  logic [31:0] card_div_q;
  logic [31:0] serial_a_q;
  logic [31:0] serial_b_q;
  logic [31:0] card_serial_q;
  logic [31:0] converter_q;
  logic [31:0] timer_sel_q;
  logic [31:0] prdata_q;
  logic pready_q;
  logic pslverr_q;

  logic hit;
  logic [31:0] rd_val;
  logic [31:0] lane_mask;
  logic setup_phase;
  logic write_now;

  assign setup_phase = psel & ~penable;
  assign write_now = psel & penable & pwrite & pready_q & hit;
  assign lane_mask = {{8{pstrb[3]}}, {8{pstrb[2]}}, {8{pstrb[1]}},
                      {8{pstrb[0]}}};

  always_comb begin
    hit = 1'b1;
    rd_val = 32'h0000_0000;
    unique case (paddr)
      CARD_CLOCK_DIV_OFS: rd_val = card_div_q;
      SERIAL_CLOCK_DIV_A_OFS: rd_val = serial_a_q;
      SERIAL_CLOCK_DIV_B_OFS: rd_val = serial_b_q;
      CARD_AND_SERIAL_CLOCK_DIV_OFS: rd_val = card_serial_q;
      CONVERTER_CLOCK_DIV_OFS: rd_val = converter_q;
      TIMER_WATCHDOG_CLOCK_SEL_OFS: rd_val = timer_sel_q;
      default: hit = 1'b0;
    endcase
  end

  // Read data and error are prepared in the setup cycle, so the access
  // phase always completes with no wait state.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= 32'h0000_0000;
    end else if (setup_phase) begin
      prdata_q <= pwrite ? 32'h0000_0000 : rd_val;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pslverr_q <= 1'b0;
    end else if (setup_phase) begin
      pslverr_q <= ~hit;
    end
  end

  // Ready is held low while reset keeps the registers at their defaults.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q <= 1'b0;
    end else begin
      pready_q <= 1'b1;
    end
  end

  // Each register has its own block; reserved bits are masked on the way
  // in, so they can never be read back as anything but zero.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      card_div_q <= CARD_CLOCK_DIV_RST;
    end else if (write_now && paddr == CARD_CLOCK_DIV_OFS) begin
      card_div_q <= ((card_div_q & ~lane_mask) | (pwdata & lane_mask))
                    & CARD_CLOCK_DIV_MASK;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      serial_a_q <= SERIAL_CLOCK_DIV_A_RST;
    end else if (write_now && paddr == SERIAL_CLOCK_DIV_A_OFS) begin
      serial_a_q <= ((serial_a_q & ~lane_mask) | (pwdata & lane_mask))
                    & SERIAL_CLOCK_DIV_MASK;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      serial_b_q <= SERIAL_CLOCK_DIV_B_RST;
    end else if (write_now && paddr == SERIAL_CLOCK_DIV_B_OFS) begin
      serial_b_q <= ((serial_b_q & ~lane_mask) | (pwdata & lane_mask))
                    & SERIAL_CLOCK_DIV_MASK;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      card_serial_q <= CARD_AND_SERIAL_CLOCK_DIV_RST;
    end else if (write_now && paddr == CARD_AND_SERIAL_CLOCK_DIV_OFS) begin
      card_serial_q <= ((card_serial_q & ~lane_mask) | (pwdata & lane_mask))
                       & CARD_AND_SERIAL_CLOCK_DIV_MASK;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      converter_q <= CONVERTER_CLOCK_DIV_RST;
    end else if (write_now && paddr == CONVERTER_CLOCK_DIV_OFS) begin
      converter_q <= ((converter_q & ~lane_mask) | (pwdata & lane_mask))
                     & CONVERTER_CLOCK_DIV_MASK;
    end
  end

  // The timer and watchdog selects are storage only; the timers decode
  // them on their own side of the port.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timer_sel_q <= TIMER_WATCHDOG_CLOCK_SEL_RST;
    end else if (write_now && paddr == TIMER_WATCHDOG_CLOCK_SEL_OFS) begin
      timer_sel_q <= ((timer_sel_q & ~lane_mask) | (pwdata & lane_mask))
                     & TIMER_WATCHDOG_CLOCK_SEL_MASK;
    end
  end

  // Source clocks are sampled on pclk, so each must stay below half the
  // pclk rate; faster sources alias rather than divide.
  logic [NUM_SRC-1:0] src_raw;
  logic [NUM_SRC-1:0] src_meta_q;
  logic [NUM_SRC-1:0] src_sync_q;
  logic [NUM_SRC-1:0] src_prev_q;
  logic [NUM_SRC-1:0] src_rise;

  assign src_raw = {twelve_mhz_crystal, second_pll_derived_clock,
                    first_pll_derived_clock, low_speed_crystal_clock,
                    main_crystal_clock};
  assign src_rise = src_sync_q & ~src_prev_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      src_meta_q <= '0;
      src_sync_q <= '0;
    end else begin
      src_meta_q <= src_raw;
      src_sync_q <= src_meta_q;
    end
  end

  // Only the second stage feeds the edge detector, so a metastable first
  // stage is never seen by the dividers.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      src_prev_q <= '0;
    end else begin
      src_prev_q <= src_sync_q;
    end
  end

  // Per channel field extraction and source decode.
  logic [7:0] ch_div [NUM_CH];
  logic [2:0] ch_src [NUM_CH];
  logic [NUM_CH-1:0] ch_valid;

  always_comb begin
    logic [31:0] fld;
    logic [1:0] sel;
    fld = 32'h0000_0000;
    sel = SEL_MAIN;
    for (int i = 0; i < NUM_SERIAL; i++) begin
      if (i < SERIAL_PER_REG) begin
        fld = serial_a_q;
      end else if (i < 2 * SERIAL_PER_REG) begin
        fld = serial_b_q;
      end else begin
        fld = card_serial_q;
      end
      fld = fld >> ((i % SERIAL_PER_REG) * SERIAL_LANE_W);
      ch_div[i] = {5'h00, fld[SERIAL_DIV_LSB +: 3]};
      sel = fld[SERIAL_SEL_LSB +: 2];
      // All four codes are legal for serial ports.
      ch_src[i] = {1'b0, sel};
      ch_valid[i] = 1'b1;
    end
    ch_div[CH_SMARTCARD1] = {5'h00, card_serial_q[SMARTCARD1_DIV_LSB +: 3]};
    ch_src[CH_SMARTCARD1] = SRC_TWELVE;
    ch_valid[CH_SMARTCARD1] = 1'b1;
    ch_div[CH_SMARTCARD0] = {4'h0, card_serial_q[SMARTCARD0_DIV_LSB +: 4]};
    ch_src[CH_SMARTCARD0] = SRC_TWELVE;
    ch_valid[CH_SMARTCARD0] = 1'b1;
    ch_div[CH_CONVERTER] = converter_q[CONVERTER_DIV_LSB +: 8];
    sel = converter_q[CONVERTER_SEL_LSB +: 2];
    ch_src[CH_CONVERTER] = {1'b0, sel};
    ch_valid[CH_CONVERTER] = (sel != SEL_LOW_OR_RSVD);
    ch_div[CH_CARD0] = card_div_q[CARD0_DIV_LSB +: 8];
    sel = card_div_q[CARD0_SEL_LSB +: 2];
    ch_src[CH_CARD0] = {1'b0, sel};
    ch_valid[CH_CARD0] = (sel != SEL_LOW_OR_RSVD);
  end

  // Each channel counts rising edges of its source. A divider of zero
  // passes the synchronised source through; otherwise the output is high
  // for the first half of the count, rounded up.
  logic [NUM_CH-1:0] eng_clk;

  for (genvar g = 0; g < NUM_CH; g++) begin : g_chan
    pecd_eng_div #(
      .DIV_W(8)
    ) u_div (
      .pclk(pclk),
      .presetn(presetn),
      .enable(ch_valid[g]),
      .src_level(src_sync_q[ch_src[g]]),
      .src_rise(src_rise[ch_src[g]]),
      .divider(ch_div[g]),
      .eng_clk(eng_clk[g])
    );
  end

  assign serial_engine_clock = eng_clk[NUM_SERIAL-1:0];
  assign smartcard_engine_clock = {eng_clk[CH_SMARTCARD1],
                                   eng_clk[CH_SMARTCARD0]};
  assign converter_engine_clock = eng_clk[CH_CONVERTER];
  assign card0_engine_clock = eng_clk[CH_CARD0];
  assign timer_watchdog_clock_sel = timer_sel_q;
  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;

endmodule : pecd_clock_div

// One engine clock divider. Its output is registered, so a divider change
// in mid-count cannot put a glitch on the engine clock.
module pecd_eng_div
  import pecd_pkg::*;
#(
  parameter int DIV_W = 8
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic enable,
  input wire logic src_level,
  input wire logic src_rise,
  input wire logic [DIV_W-1:0] divider,
  output logic eng_clk
);

  logic [DIV_W-1:0] cnt_q;
  logic eng_q;

  // A smaller divider written mid-count takes effect at once: the count
  // wraps on the next source rise once it has reached or passed the new value.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= '0;
    end else if (!enable) begin
      cnt_q <= '0;
    end else if (src_rise) begin
      cnt_q <= (cnt_q >= divider) ? '0 : cnt_q + DIV_W'(1);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      eng_q <= 1'b0;
    end else if (!enable) begin
      eng_q <= 1'b0;
    end else if (divider == '0) begin
      eng_q <= src_level;
    end else begin
      eng_q <= (cnt_q <= (divider >> 1));
    end
  end

  assign eng_clk = eng_q;

endmodule : pecd_eng_div

// ### test/pecd_clock_div_chk.sv
`timescale 1ns/10ps
module pecd_clock_div_chk
  import pecd_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic converter_engine_clock,
  input wire logic card0_engine_clock,
  input wire logic [31:0] timer_watchdog_clock_sel
);
  logic conv_rsv_q;
  logic card_rsv_q;
  logic wr;
  logic setup;
  logic map;
  logic tw_hit;
  assign wr = psel && penable && pwrite;
  assign setup = psel && !penable;
  assign map = paddr[1:0] == 2'h0 && paddr >= 12'h02C && paddr <= 12'h040;
  assign tw_hit = paddr == 12'h040;
  // Shadow the reserved selections from the bus, as only ports are seen.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      conv_rsv_q <= 1'b0;
      card_rsv_q <= 1'b0;
    end else if (wr && pstrb[2] && paddr == 12'h03C) begin
      conv_rsv_q <= pwdata[20:19] == 2'h1;
    end else if (wr && pstrb[0] && paddr == 12'h02C) begin
      card_rsv_q <= pwdata[4:3] == 2'h1;
    end
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  chk_ready_access: assert property (psel && penable |-> pready)
    else $error("pready low in access phase");
  chk_err_unmapped: assert property (setup && !map |=>
    pslverr && prdata == 32'h0) else $error("unmapped access not refused");
  chk_err_mapped: assert property (setup && map |=> !pslverr)
    else $error("mapped access refused");
  chk_write_rdata: assert property (setup && pwrite |=> prdata == 32'h0)
    else $error("read data not zero during write");
  chk_tw_write: assert property (wr && tw_hit && pstrb == 4'hF |=>
    timer_watchdog_clock_sel == ($past(pwdata) & 32'h0FFF_0FFF))
    else $error("select register write not seen");
  chk_tw_hold: assert property (!(wr && tw_hit) |=>
    $stable(timer_watchdog_clock_sel)) else $error("select register moved");
  chk_tw_read: assert property (setup && !pwrite && tw_hit |=>
    prdata == timer_watchdog_clock_sel) else $error("select readback wrong");
  chk_conv_reserved: assert property (
    conv_rsv_q [*3] |-> !converter_engine_clock) else $error("converter runs");
  chk_card_reserved: assert property (
    card_rsv_q [*3] |-> !card0_engine_clock) else $error("card clock runs");
  cov_unmapped: cover property (setup && !map);
  cov_conv_rsv: cover property (conv_rsv_q [*3]);
  cov_tw_write: cover property (wr && tw_hit);
endmodule : pecd_clock_div_chk

bind pecd_clock_div pecd_clock_div_chk u_chk (.pclk, .presetn, .psel,
  .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr,
  .converter_engine_clock, .card0_engine_clock, .timer_watchdog_clock_sel);

// ### test/pecd_clock_div_test.sv
`timescale 1ns/10ps
module pecd_clock_div_test import pecd_pkg::*;;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, conv, card0, e;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, tw, rd;
  logic [3:0] pstrb;
  logic [4:0] src = 5'h00;
  logic [NUM_SERIAL-1:0] ser;
  logic [1:0] smc;
  logic [NUM_CH-1:0] eng;
  int error_cnt, tests_run, p, hi;
  int cnt[5];
  int half[5] = '{4, 10, 6, 8, 5};
  logic [11:0] ofs[6] = '{12'h02C, 12'h030, 12'h034, 12'h038, 12'h03C,
    12'h040};
  logic [31:0] rst[6] = '{6{32'h0}};
  logic [31:0] msk[6] = '{32'h0000FF18, 32'hF8F8F8F8, 32'hF8F8F8F8,
    32'h7F00F8F8, 32'hFF180000, 32'h0FFF0FFF};
  logic [11:0] ca[18] = '{12'h030, 12'h030, 12'h030, 12'h030, 12'h034,
    12'h034, 12'h034, 12'h034, 12'h038, 12'h038, 12'h038, 12'h038, 12'h03C,
    12'h03C, 12'h03C, 12'h02C, 12'h02C, 12'h02C};
  logic [31:0] cv[18] = '{32'h40, 32'h28000000, 32'h1800, 32'hF00000, 32'h70,
    32'h8000000, 32'hA00000, 32'h5800, 32'h38, 32'hC800, 32'hF000000,
    32'h70000000, 32'hFF180000, 32'h2100000, 32'h2000000, 32'h410, 32'h18,
    32'h100};
  int cc[18] = '{0, 3, 1, 2, 4, 7, 6, 5, 8, 9, 10, 11, 12, 12, 12, 13, 13, 13};
  int cp[18] = '{24, 40, 16, 96, 48, 20, 48, 48, 32, 140, 160, 80, 4096, 36,
    24, 60, 16, 16};
  assign eng = {card0, conv, smc, ser};
  pecd_clock_div dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .pstrb, .prdata, .pready, .pslverr,
    .main_crystal_clock(src[0]), .low_speed_crystal_clock(src[1]),
    .first_pll_derived_clock(src[2]), .second_pll_derived_clock(src[3]),
    .twelve_mhz_crystal(src[4]), .serial_engine_clock(ser),
    .smartcard_engine_clock(smc), .converter_engine_clock(conv),
    .card0_engine_clock(card0), .timer_watchdog_clock_sel(tw));
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  // Sources are pclk-locked, so every engine period is an exact count.
  always @(posedge pclk) begin
    for (int k = 0; k < 5; k++) begin
      if (cnt[k] == half[k] - 1) begin
        cnt[k] <= 0;
        src[k] <= ~src[k];
      end else begin
        cnt[k] <= cnt[k] + 1;
      end
    end
  end
  task complete_run();
    $display("checks %0d errors %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : complete_run
  task tmo();
    error_cnt++;
    $display("[FAIL] wait expected done seen timeout");
    complete_run();
  endtask : tmo
  task chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d,
    input logic [3:0] s);
    int i;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge pclk);
    penable <= 1'b1;
    i = 0;
    do begin
      @(posedge pclk);
      i++;
    end while (pready !== 1'b1 && i < 50);
    if (i >= 50) tmo();
    rd = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task rise(input int ch, output int n);
    logic pv;
    for (n = 1; n < 5000; n++) begin
      pv = eng[ch];
      @(posedge pclk);
      if (pv === 1'b0 && eng[ch] === 1'b1) break;
    end
    if (n >= 5000) tmo();
  endtask : rise
  task quiet(input int ch);
    hi = 0;
    repeat (10) @(posedge pclk);
    repeat (300) @(posedge pclk) if (eng[ch] !== 1'b0) hi++;
    chk("held low", hi, 32'h0);
  endtask : quiet
  task per(input int k);
    apb(1'b1, ca[k], cv[k], 4'hF);
    rise(cc[k], p);
    rise(cc[k], p);
    rise(cc[k], p);
  endtask : per
  initial begin
    {psel, penable, pwrite, presetn} = 4'h0;
    {paddr, pwdata, pstrb} = '0;
    rst[5] = 32'h0000_0500;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    for (int k = 0; k < 6; k++) begin
      apb(1'b0, ofs[k], 32'h0, 4'h0);
      chk("reset value", rd, rst[k]);
      chk("mapped err", {31'h0, e}, 32'h0);
      apb(1'b1, ofs[k], 32'hFFFF_FFFF, 4'hF);
      apb(1'b0, ofs[k], 32'h0, 4'h0);
      chk("writable bits", rd, msk[k]);
      apb(1'b1, ofs[k], rst[k], 4'hF);
    end
    apb(1'b1, 12'h040, 32'hFFFF_FFFF, 4'h1);
    apb(1'b0, 12'h040, 32'h0, 4'h0);
    chk("strobe read", rd, 32'h0000_05FF);
    chk("select port", tw, 32'h0000_05FF);
    apb(1'b1, 12'h100, 32'hFFFF_FFFF, 4'hF);
    chk("unmapped err", {31'h0, e}, 32'h1);
    apb(1'b0, 12'h100, 32'h0, 4'h0);
    chk("unmapped data", rd, 32'h0);
    for (int k = 0; k < 4; k++) begin
      per(k);
      chk("period", p, cp[k]);
    end
    for (int k = 4; k < 8; k++) begin
      per(k);
      chk("period", p, cp[k]);
    end
    for (int k = 8; k < 10; k++) begin
      per(k);
      chk("period", p, cp[k]);
    end
    for (int k = 10; k < 12; k++) begin
      per(k);
      chk("period", p, cp[k]);
    end
    for (int k = 12; k < 15; k++) begin
      per(k);
      chk("period", p, cp[k]);
    end
    for (int k = 15; k < 18; k++) begin
      per(k);
      chk("period", p, cp[k]);
    end
    apb(1'b1, 12'h03C, 32'h0008_0000, 4'hF);
    quiet(CH_CONVERTER);
    apb(1'b1, 12'h02C, 32'h0000_0008, 4'hF);
    quiet(CH_CARD0);
    presetn <= 1'b0;
    repeat (5) @(posedge pclk);
    chk("select in reset", tw, 32'h0000_0500);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, 12'h02C, 32'h0, 4'h0);
    chk("second reset", rd, 32'h0);
    complete_run();
  end
endmodule : pecd_clock_div_test
